// ---- hdl/chan_five_defines.vh ----
// constants for the channel five output control block
`ifndef CHAN_FIVE_DEFINES_VH
`define CHAN_FIVE_DEFINES_VH

// register indices (printed offsets are not all multiples of four)
`define REG_IDX_OUTPUT_CONTROL  8'h27
`define REG_IDX_OUTPUT_DIVIDER  8'h28
`define REG_IDX_CHANNEL_STATUS  8'h29
// byte addresses are four times the index
`define ADDR_OUTPUT_CONTROL     12'h09C
`define ADDR_OUTPUT_DIVIDER     12'h0A0
`define ADDR_CHANNEL_STATUS     12'h0A4

// control register fields
`define CTL_SRC_HI              7
`define CTL_SRC_LO              6
`define CTL_DRV_HI              5
`define CTL_DRV_LO              4
`define CTL_MODE1_HI            3
`define CTL_MODE1_LO            2
`define CTL_MODE2_HI            1
`define CTL_MODE2_LO            0

// reset values
`define RST_SOURCE              2'h0
`define RST_DRIVER              2'h1
`define RST_MODE1               2'h2
`define RST_MODE2               2'h0
`define RST_DIVIDER             8'h02

// source select codes
`define SRC_SYNTH_FIRST         2'h0
`define SRC_SYNTH_SECOND        2'h1
`define SRC_REF_PRIMARY         2'h2
`define SRC_REF_SECONDARY       2'h3

// driver select codes
`define DRV_DISABLED            2'h0
`define DRV_AC_DIFF             2'h1
`define DRV_HCSL                2'h2
`define DRV_LVCMOS              2'h3

// single-ended pin mode codes
`define PIN_OFF_TRISTATE        2'h0
`define PIN_OFF_LOW             2'h1
`define PIN_ON_INVERTED         2'h2
`define PIN_ON_TRUE             2'h3

// tail current settings in mA
`define TAIL_CODE0_MA           5'h04
`define TAIL_CODE1_MA           5'h06
`define TAIL_CODE2_MA           5'h08
`define TAIL_CODE3_MA           5'h10

// hcsl load settings in ohms, zero meaning tristate
`define LOAD_CODE0_OHM          8'h00
`define LOAD_CODE1_OHM          8'h32
`define LOAD_CODE2_OHM          8'h64
`define LOAD_CODE3_OHM          8'hC8

// ahb-lite encodings
`define HTRANS_NONSEQ           2'h2
`define HSIZE_WORD              3'h2
`define HRESP_OKAY              1'b0

`endif

// ---- hdl/chan_post_divider.v ----
// post-divider for the channel clock, ratio code plus one
`timescale 1ns/1ps
`default_nettype none

`include "chan_five_defines.vh"

module chan_post_divider
(
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       clk_in,
    input  wire       bypass,
    input  wire [7:0] div_code,
    output wire       clk_out
);

    // =========================================================
    // edge counter
    // =========================================================
    // clk_in is treated as a sampled level; a change of div_code takes
    // effect at the next wrap, which keeps the output free of runt pulses
    reg  [7:0] count;
    reg  [7:0] code_hold;
    reg        clk_in_last;
    reg        div_clk;
    wire       rise;

    assign rise = clk_in & ~clk_in_last;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count       <= 8'h00;
            code_hold   <= `RST_DIVIDER;
            clk_in_last <= 1'b0;
            div_clk     <= 1'b0;
        end
        else
        begin
            clk_in_last <= clk_in;
            if (rise)
            begin
                // output high for the first half of code+1 input periods
                if (count == code_hold)
                begin
                    count     <= 8'h00;
                    code_hold <= div_code;
                    div_clk   <= 1'b1;
                end
                else
                begin
                    count   <= count + 8'h01;
                    div_clk <= ((count + 8'h01) <= (code_hold >> 1));
                end
            end
            else if (code_hold == 8'h00 && !clk_in)
            begin
                div_clk <= 1'b0;
            end
        end
    end

    // references skip the divider
    assign clk_out = bypass ? clk_in : div_clk;

endmodule

`default_nettype wire

// ---- hdl/chan_pin_driver.v ----
// output pin driver for one channel: driver type and pin modes
`timescale 1ns/1ps
`default_nettype none

`include "chan_five_defines.vh"

module chan_pin_driver
(
    input  wire       clk_in,
    input  wire [1:0] driver_select,
    input  wire [1:0] driver_mode_first,
    input  wire [1:0] driver_mode_second,
    output reg        out_p,
    output reg        out_p_oe_n,
    output reg        out_n,
    output reg        out_n_oe_n,
    output reg        diff_enable,
    output reg        hcsl_enable,
    output reg  [4:0] tail_current_ma,
    output reg  [7:0] load_ohm
);

    function [1:0] pin_level;
        input [1:0] mode;
        input       clk;
        begin
            // bit 1 is the drive level, bit 0 the active-low enable
            case (mode)
                `PIN_OFF_TRISTATE: pin_level = 2'b01;
                `PIN_OFF_LOW:      pin_level = 2'b00;
                `PIN_ON_INVERTED:  pin_level = {~clk, 1'b0};
                default:           pin_level = {clk, 1'b0};
            endcase
        end
    endfunction

    reg [1:0] lvl_p;
    reg [1:0] lvl_n;

    always @*
    begin
        lvl_p           = pin_level(driver_mode_first, clk_in);
        lvl_n           = pin_level(driver_mode_second, clk_in);
        out_p           = 1'b0;
        out_p_oe_n      = 1'b1;
        out_n           = 1'b0;
        out_n_oe_n      = 1'b1;
        diff_enable     = 1'b0;
        hcsl_enable     = 1'b0;
        tail_current_ma = 5'h00;
        load_ohm        = `LOAD_CODE0_OHM;
        case (driver_select)
            `DRV_LVCMOS:
            begin
                out_p      = lvl_p[1];
                out_p_oe_n = lvl_p[0];
                out_n      = lvl_n[1];
                out_n_oe_n = lvl_n[0];
            end
            `DRV_AC_DIFF, `DRV_HCSL:
            begin
                diff_enable = 1'b1;
                hcsl_enable = (driver_select == `DRV_HCSL);
                out_p       = clk_in;
                out_n       = ~clk_in;
                out_p_oe_n  = 1'b0;
                out_n_oe_n  = 1'b0;
                case (driver_mode_first)
                    2'h0:    tail_current_ma = `TAIL_CODE0_MA;
                    2'h1:    tail_current_ma = `TAIL_CODE1_MA;
                    2'h2:    tail_current_ma = `TAIL_CODE2_MA;
                    default: tail_current_ma = `TAIL_CODE3_MA;
                endcase
                if (driver_select == `DRV_HCSL)
                begin
                    case (driver_mode_second)
                        2'h0:    load_ohm = `LOAD_CODE0_OHM;
                        2'h1:    load_ohm = `LOAD_CODE1_OHM;
                        2'h2:    load_ohm = `LOAD_CODE2_OHM;
                        default: load_ohm = `LOAD_CODE3_OHM;
                    endcase
                end
            end
            default:
            begin
                out_p = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- hdl/output_channel_five_control.v ----
// channel five output control: ahb-lite registers, source mux, divider, driver
`timescale 1ns/1ps
`default_nettype none

`include "chan_five_defines.vh"

// Behaviour
// - source field 0..3 picks first synth, second synth, primary ref, secondary ref
// - driver select 0..3: disabled, ac differential, hcsl, lvcmos
// - lvcmos positive pin follows first mode: tristate, low, inverted, true
// - lvcmos negative pin follows second mode with the same code meanings
// - channel clock divided by divider field plus one, 1 to 256
// - divider used only for synthesizer sources, references bypass it
// - divider resets to 0x02, ratio three, also in startup image
module output_channel_five_control
(
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // clock sources; synthesizers sampled as levels by the divider, references passed straight through
    input  wire        first_synthesizer,
    input  wire        second_synthesizer,
    input  wire        ref_primary,
    input  wire        ref_secondary,
    // startup image of the two registers
    input  wire        image_load,
    input  wire [7:0]  image_control,
    input  wire [7:0]  image_divider,
    output wire [7:0]  image_divider_store,
    // output pins and driver settings
    output wire        out_p,
    output wire        out_p_oe_n,
    output wire        out_n,
    output wire        out_n_oe_n,
    output wire        diff_enable,
    output wire        hcsl_enable,
    output wire [4:0]  tail_current_ma,
    output wire [7:0]  load_ohm
);

    // =========================================================
    // registers
    // =========================================================
    reg  [1:0] chan_source_select;
    reg  [1:0] driver_select;
    reg  [1:0] driver_mode_first;
    reg  [1:0] driver_mode_second;
    reg  [7:0] divider_code;

    wire [7:0] control_value;
    assign control_value = {chan_source_select, driver_select,
                            driver_mode_first, driver_mode_second};

    // =========================================================
    // ahb-lite slave
    // =========================================================
    // zero wait state: every access completes in its first data-phase cycle
    reg        dp_write;
    reg [11:0] dp_addr;
    wire       take;

    // sub-word transfers are not taken: each register fills one whole word
    assign take      = hsel & hready & (htrans == `HTRANS_NONSEQ) &
                       (hsize == `HSIZE_WORD);
    assign hreadyout = 1'b1;
    assign hresp     = `HRESP_OKAY;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_write <= 1'b0;
            dp_addr  <= 12'h000;
        end
        else if (hready)
        begin
            dp_write <= take & hwrite;
            dp_addr  <= haddr;
        end
    end

    function [31:0] read_mux;
        input [11:0] addr;
        input [7:0]  ctl;
        input [7:0]  dvd;
        input [7:0]  sts;
        begin
            if (addr == `ADDR_OUTPUT_CONTROL)
                read_mux = {24'h00_0000, ctl};
            else if (addr == `ADDR_OUTPUT_DIVIDER)
                read_mux = {24'h00_0000, dvd};
            else if (addr == `ADDR_CHANNEL_STATUS)
                read_mux = {24'h00_0000, sts};
            else
                read_mux = 32'h0000_0000;
        end
    endfunction

    // =========================================================
    // register writes and startup image load
    // =========================================================
    // next_ values carry the write completing in this cycle, so a read
    // taken at the same edge already returns the new contents
    reg  [7:0] next_control;
    reg  [7:0] next_divider;

    always @*
    begin
        next_control = control_value;
        next_divider = divider_code;
        if (dp_write && dp_addr == `ADDR_OUTPUT_CONTROL)
        begin
            next_control = hwdata[7:0];
        end
        else if (dp_write && dp_addr == `ADDR_OUTPUT_DIVIDER)
        begin
            next_divider = hwdata[7:0];
        end
        else if (image_load)
        begin
            // a bus write in the same cycle wins over the image load
            next_control = image_control;
            next_divider = image_divider;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            chan_source_select <= `RST_SOURCE;
            driver_select      <= `RST_DRIVER;
            driver_mode_first  <= `RST_MODE1;
            driver_mode_second <= `RST_MODE2;
            divider_code       <= `RST_DIVIDER;
        end
        else
        begin
            chan_source_select <= next_control[`CTL_SRC_HI:`CTL_SRC_LO];
            driver_select      <= next_control[`CTL_DRV_HI:`CTL_DRV_LO];
            driver_mode_first  <= next_control[`CTL_MODE1_HI:`CTL_MODE1_LO];
            driver_mode_second <= next_control[`CTL_MODE2_HI:`CTL_MODE2_LO];
            divider_code       <= next_divider;
        end
    end

    // the image keeps the live divider so a save captures it
    assign image_divider_store = divider_code;

    // =========================================================
    // source selection
    // =========================================================
    reg  source_clk;
    wire from_synth;

    always @*
    begin
        case (chan_source_select)
            `SRC_SYNTH_FIRST:  source_clk = first_synthesizer;
            `SRC_SYNTH_SECOND: source_clk = second_synthesizer;
            `SRC_REF_PRIMARY:  source_clk = ref_primary;
            default:           source_clk = ref_secondary;
        endcase
    end

    assign from_synth = (chan_source_select == `SRC_SYNTH_FIRST) |
                        (chan_source_select == `SRC_SYNTH_SECOND);

    wire chan_clk;

    chan_post_divider u_div
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .clk_in   (source_clk),
        .bypass   (~from_synth),
        .div_code (divider_code),
        .clk_out  (chan_clk)
    );

    chan_pin_driver u_drv
    (
        .clk_in             (chan_clk),
        .driver_select      (driver_select),
        .driver_mode_first  (driver_mode_first),
        .driver_mode_second (driver_mode_second),
        .out_p              (out_p),
        .out_p_oe_n         (out_p_oe_n),
        .out_n              (out_n),
        .out_n_oe_n         (out_n_oe_n),
        .diff_enable        (diff_enable),
        .hcsl_enable        (hcsl_enable),
        .tail_current_ma    (tail_current_ma),
        .load_ohm           (load_ohm)
    );

    // =========================================================
    // read data
    // =========================================================
    // status: bit0 divider in use, bit1 current channel clock level
    wire [7:0] status_value;
    assign status_value = {6'h00, chan_clk, from_synth};

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= read_mux(haddr, next_control, next_divider, status_value);
    end

endmodule

`default_nettype wire

// ---- testbench/output_channel_five_checker.sv ----
// assertions on the ports of the channel five output control block
`timescale 1ns/1ps
`default_nettype none

`include "chan_five_defines.vh"

module output_channel_five_checker
(
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [11:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        image_load,
    input wire [7:0]  image_divider,
    input wire [7:0]  image_divider_store,
    input wire        out_p,
    input wire        out_p_oe_n,
    input wire        out_n,
    input wire        out_n_oe_n,
    input wire        diff_enable,
    input wire        hcsl_enable,
    input wire [4:0]  tail_current_ma,
    input wire [7:0]  load_ohm
);
    // ====================
    // transfer decode
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && hready && htrans == `HTRANS_NONSEQ;
    wire mapped = haddr == `ADDR_OUTPUT_CONTROL || haddr == `ADDR_OUTPUT_DIVIDER
                  || haddr == `ADDR_CHANNEL_STATUS;

    // ====================
    // properties
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    reset_values_a: assert property ($rose(hresetn) |-> image_divider_store == 8'h02
        && diff_enable && tail_current_ma == 5'h08) else $error("bad values after reset");
    // the write lands at the data phase edge, so the store shows it one edge later
    div_write_a: assert property (take && hwrite && haddr == `ADDR_OUTPUT_DIVIDER
        |=> ##1 image_divider_store == $past(hwdata[7:0])) else $error("divider not written");
    image_load_a: assert property (image_load && !$past(take && hwrite) |=>
        image_divider_store == $past(image_divider)) else $error("image not loaded");
    read_upper_a: assert property (take && !hwrite |=> hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    unmapped_read_a: assert property (take && !hwrite && !mapped |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    hcsl_diff_a: assert property (hcsl_enable |-> diff_enable)
        else $error("hcsl without differential");
    tail_code_a: assert property (diff_enable ? tail_current_ma inside {5'h04, 5'h06, 5'h08,
        5'h10} : tail_current_ma == 5'h00) else $error("bad tail current");
    load_code_a: assert property (hcsl_enable ? load_ohm inside {8'h00, 8'h32, 8'h64,
        8'hC8} : load_ohm == 8'h00) else $error("bad hcsl load");
    diff_pins_a: assert property (diff_enable |-> !out_p_oe_n && !out_n_oe_n
        && out_n != out_p) else $error("differential pins not complementary");
    cover property (take && hwrite);
    cover property (hcsl_enable);
    cover property (!diff_enable && !out_p_oe_n);
endmodule

bind output_channel_five_control output_channel_five_checker chk
(
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .image_load, .image_divider, .image_divider_store, .out_p, .out_p_oe_n,
    .out_n, .out_n_oe_n, .diff_enable,
    .hcsl_enable, .tail_current_ma, .load_ohm
);

`default_nettype wire

// ---- testbench/output_channel_five_control_tb.sv ----
// self-checking bench for the channel five output control block
`timescale 1ns/1ps
`default_nettype none

`include "chan_five_defines.vh"

module output_channel_five_control_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        first_synthesizer = 1'b0;
    logic        second_synthesizer = 1'b0;
    logic        ref_primary = 1'b0;
    logic        ref_secondary = 1'b0;
    logic        image_load = 1'b0;
    logic [7:0]  image_control = 8'h00;
    logic [7:0]  image_divider = 8'h00;
    wire         hreadyout, hresp, out_p, out_p_oe_n, out_n, out_n_oe_n;
    wire         diff_enable, hcsl_enable;
    wire  [31:0] hrdata;
    wire  [7:0]  image_divider_store;
    wire  [4:0]  tail_current_ma;
    wire  [7:0]  load_ohm;
    logic [31:0] v;
    integer      errors = 0;
    integer      check_count = 0;
    logic [4:0]  tail_tab [0:3] = '{5'h04, 5'h06, 5'h08, 5'h10};
    logic [7:0]  load_tab [0:3] = '{8'h00, 8'h32, 8'h64, 8'hC8};

    always #5 hclk = ~hclk;

    output_channel_five_control uut
    (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(`HSIZE_WORD), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .first_synthesizer,
        .second_synthesizer, .ref_primary, .ref_secondary, .image_load,
        .image_control, .image_divider, .image_divider_store, .out_p,
        .out_p_oe_n, .out_n, .out_n_oe_n, .diff_enable, .hcsl_enable, .tail_current_ma,
        .load_ohm
    );

    // ====================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // the leading edge keeps one idle cycle between transfers, so read-back never
    // overlaps the data phase of the write before it
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= `HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    // ====================
    // scenarios
    task automatic test_reset;
        ahb(1'b0, `ADDR_OUTPUT_CONTROL, 32'h0000_0000, v);
        check(v, 32'h0000_0018);
        ahb(1'b0, `ADDR_OUTPUT_DIVIDER, 32'h0000_0000, v);
        check(v, 32'h0000_0002);
        ahb(1'b0, `ADDR_CHANNEL_STATUS, 32'h0000_0000, v);
        check(v, 32'h0000_0001);
        check(image_divider_store, 32'h0000_0002);
        check({diff_enable, hcsl_enable, tail_current_ma}, 32'h0000_0048);
        $display("test_reset done");
    endtask

    task automatic test_regs;
        ahb(1'b1, `ADDR_OUTPUT_CONTROL, 32'hFFFF_FFA5, v);
        ahb(1'b1, `ADDR_OUTPUT_DIVIDER, 32'h1234_56FF, v);
        ahb(1'b1, 12'h0FC, 32'h0000_00FF, v);
        ahb(1'b0, `ADDR_OUTPUT_CONTROL, 32'h0000_0000, v);
        check(v, 32'h0000_00A5);
        ahb(1'b0, `ADDR_OUTPUT_DIVIDER, 32'h0000_0000, v);
        check(v, 32'h0000_00FF);
        check(image_divider_store, 32'h0000_00FF);
        ahb(1'b0, 12'h0FC, 32'h0000_0000, v);
        check(v, 32'h0000_0000);
        $display("test_regs done");
    endtask

    task automatic test_image;
        image_control <= 8'hE7;
        image_divider <= 8'h3C;
        image_load    <= 1'b1;
        @(posedge hclk);
        image_load    <= 1'b0;
        ahb(1'b0, `ADDR_OUTPUT_CONTROL, 32'h0000_0000, v);
        check(v, 32'h0000_00E7);
        ahb(1'b0, `ADDR_OUTPUT_DIVIDER, 32'h0000_0000, v);
        check(v, 32'h0000_003C);
        check(image_divider_store, 32'h0000_003C);
        $display("test_image done");
    endtask

    task automatic test_modes;
        integer d, m1, m2;
        logic   diff, hcsl;
        ref_primary <= 1'b1;
        for (d = 0; d < 4; d = d + 1)
            for (m1 = 0; m1 < 4; m1 = m1 + 1)
                for (m2 = 0; m2 < 4; m2 = m2 + 1)
                begin
                    ahb(1'b1, `ADDR_OUTPUT_CONTROL,
                        {24'h00_0000, `SRC_REF_PRIMARY, d[1:0], m1[1:0], m2[1:0]}, v);
                    repeat (3) @(posedge hclk);
                    #1;
                    diff = d == 1 || d == 2;
                    hcsl = d == 2;
                    check(diff_enable, diff);
                    check(hcsl_enable, hcsl);
                    check(tail_current_ma, diff ? tail_tab[m1] : 5'h00);
                    check(load_ohm, hcsl ? load_tab[m2] : 8'h00);
                    if (d == 3)
                    begin
                        check({out_p_oe_n, out_n_oe_n}, {m1 == 0, m2 == 0});
                        if (m1 != 0) check(out_p, m1 == 3);
                        if (m2 != 0) check(out_n, m2 == 3);
                    end
                    else if (d == 0)
                        check({out_p_oe_n, out_n_oe_n}, 32'h0000_0003);
                    else
                        check({out_p_oe_n, out_n_oe_n, out_p, out_n}, 32'h0000_0002);
                end
        $display("test_modes done");
    endtask

    task automatic level_case(input logic [1:0] src, input logic lvl);
        ahb(1'b1, `ADDR_OUTPUT_CONTROL,
            {24'h00_0000, src, `DRV_LVCMOS, `PIN_ON_TRUE, `PIN_ON_INVERTED}, v);
        ref_primary   <= (src == `SRC_REF_PRIMARY) ? lvl : ~lvl;
        ref_secondary <= (src == `SRC_REF_SECONDARY) ? lvl : ~lvl;
        repeat (3) @(posedge hclk);
        #1;
        check({out_p, out_n}, {30'h0000_0000, lvl, ~lvl});
    endtask

    // the source toggles every cycle, so one output period is twice the ratio in cycles
    task automatic synth_case(input logic [1:0] src, input logic [7:0] code);
        integer t;
        integer last = 0;
        integer rises = 0;
        integer period = 0;
        logic   prev = 1'b1;
        ahb(1'b1, `ADDR_OUTPUT_DIVIDER, {24'h00_0000, code}, v);
        ahb(1'b1, `ADDR_OUTPUT_CONTROL,
            {24'h00_0000, src, `DRV_LVCMOS, `PIN_ON_TRUE, `PIN_ON_INVERTED}, v);
        for (t = 0; t < 2500 && rises < 4; t = t + 1)
        begin
            @(posedge hclk);
            if (src[0]) second_synthesizer <= ~second_synthesizer;
            else first_synthesizer <= ~first_synthesizer;
            #1;
            if (out_p === 1'b1 && prev === 1'b0)
            begin
                rises = rises + 1;
                period = t - last;
                last = t;
            end
            prev = out_p;
        end
        check(period, 2 * (code + 32'h0000_0001));
    endtask

    task automatic test_sources;
        ahb(1'b1, `ADDR_OUTPUT_DIVIDER, 32'h0000_0004, v);
        level_case(`SRC_REF_PRIMARY, 1'b0);
        level_case(`SRC_REF_PRIMARY, 1'b1);
        level_case(`SRC_REF_SECONDARY, 1'b0);
        level_case(`SRC_REF_SECONDARY, 1'b1);
        synth_case(`SRC_SYNTH_FIRST, 8'h00);
        synth_case(`SRC_SYNTH_FIRST, 8'h04);
        synth_case(`SRC_SYNTH_SECOND, 8'h01);
        synth_case(`SRC_SYNTH_FIRST, 8'hFF);
        $display("test_sources done");
    endtask

    // ====================
    // main sequence and watchdog
    initial
    begin
        do_reset;
        test_reset;
        test_regs;
        test_image;
        do_reset;
        test_reset;
        test_modes;
        test_sources;
        end_of_test;
    end

    initial
    begin
        #300000;
        errors = errors + 1;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test;
    end
endmodule

`default_nettype wire
